// ---- verilog/rtw_slave_port.sv ----
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - The port only ever acts as a slave and answers only a start followed by address 7'h68.
// - Twenty byte locations are reachable in order, clock bytes first, square-wave byte last.
// - Both lines high means the bus is idle, and the master starts only from idle.
// - Data falling while the clock is high is a start and begins every transfer.
// - Data rising while the clock is high is a stop and ends the transfer.
// - Data is held stable while the clock is high and changes only while it is low.
// - Bytes are eight bits plus a ninth acknowledge bit, any number per transfer.
// - The receiver acknowledges by holding data low through the high of the ninth clock.
// - A reading master ends with no acknowledge and the port then releases the data line.
// - After a write address the next byte loads the pointer and later bytes are stored.
// - The port acknowledges its address, the word address and every written byte.
// - The pointer advances by one only on an acknowledge clock, in reads and writes.
// - An addressed read is a pointer write, a repeated start and a read of that location.
// - Reading continues from consecutive locations until the master withholds the acknowledge or issues a stop.
// - A read with no pointer write begins at the location last held in the pointer.
// - The clock copy update is held while the port is selected and the pointer is on a clock location.
module rtw_slave_port #(
    parameter int unsigned NUM_REGS = rtw_pkg::NUM_REGS
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_clk,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe_n,
    input  wire logic       core_wr_en,
    input  wire logic [4:0] core_addr,
    input  wire logic [7:0] core_wdata,
    output var  logic [7:0] core_rdata,
    output var  logic       clk_update_hold,
    output var  logic       bus_wr_strobe,
    output var  logic [4:0] bus_wr_addr
);

    // Pointer step with wrap at the top of the map
    function automatic logic [4:0] ptr_inc(input logic [4:0] p);
        ptr_inc = (p == rtw_pkg::LAST_ADDR) ? rtw_pkg::FIRST_ADDR : 5'(p + 5'h01);
    endfunction

    // Clock locations are the first eight of the map
    function automatic logic is_clock_addr(input logic [4:0] p);
        is_clock_addr = (p <= rtw_pkg::LAST_CLOCK);
    endfunction

    // ------------------------------------------------------------------
    // Link domain: runs on the bus clock itself, so each bit is caught
    // exactly at its rising edge instead of by oversampling.
    // Reset is released while the bus clock stands high, so these flops
    // leave reset with no edge pending.
    // ------------------------------------------------------------------
    logic lk_bit_ff;
    logic lk_tgl_ff;

    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_bit_ff <= rtw_pkg::PIN_IDLE;
            lk_tgl_ff <= 1'b0;
        end else begin
            lk_bit_ff <= sda_i;
            lk_tgl_ff <= ~lk_tgl_ff;
        end
    end

    // ------------------------------------------------------------------
    // System domain synchronisers. The bus clock only moves while a frame
    // runs, so the toggle may sit still for long stretches; that is fine,
    // nothing here waits for a link edge outside a frame.
    // lk_bit_ff is read raw: it moves only on the next bus rise, long after the toggle.
    // ------------------------------------------------------------------
    logic scl_m_ff;
    logic scl_s_ff;
    logic scl_p_ff;
    logic sda_m_ff;
    logic sda_s_ff;
    logic sda_p_ff;
    logic tgl_m_ff;
    logic tgl_s_ff;
    logic tgl_p_ff;

    // Two flops per crossing, a third for edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m_ff <= rtw_pkg::PIN_IDLE;
            scl_s_ff <= rtw_pkg::PIN_IDLE;
            scl_p_ff <= rtw_pkg::PIN_IDLE;
            sda_m_ff <= rtw_pkg::PIN_IDLE;
            sda_s_ff <= rtw_pkg::PIN_IDLE;
            sda_p_ff <= rtw_pkg::PIN_IDLE;
            tgl_m_ff <= 1'b0;
            tgl_s_ff <= 1'b0;
            tgl_p_ff <= 1'b0;
        end else begin
            scl_m_ff <= scl_clk;
            scl_s_ff <= scl_m_ff;
            scl_p_ff <= scl_s_ff;
            sda_m_ff <= sda_i;
            sda_s_ff <= sda_m_ff;
            sda_p_ff <= sda_s_ff;
            tgl_m_ff <= lk_tgl_ff;
            tgl_s_ff <= tgl_m_ff;
            tgl_p_ff <= tgl_s_ff;
        end
    end

    // Bus condition decode
    wire scl_high_w = scl_s_ff & scl_p_ff;
    // idle when both high, one sample back
    wire bus_idle_w = scl_p_ff & sda_p_ff;
    // start detect: leaving idle by data falling under a high clock
    wire start_det  = bus_idle_w & scl_s_ff & ~sda_s_ff;
    wire stop_det   = scl_high_w & ~sda_p_ff & sda_s_ff;
    // Rising edge seen through the toggle; the captured bit is stable by now
    wire rise_ev    = tgl_s_ff ^ tgl_p_ff;
    wire fall_ev    = scl_p_ff & ~scl_s_ff;

    // ------------------------------------------------------------------
    // Protocol state
    // ------------------------------------------------------------------
    rtw_pkg::rtw_state_t state_ff;
    rtw_pkg::rtw_state_t nxt_state;
    logic [3:0] bitn_ff;
    logic [3:0] nxt_bitn;
    logic [7:0] sh_ff;
    logic [7:0] nxt_sh;
    logic [7:0] tx_ff;
    logic [7:0] nxt_tx;
    logic [4:0] ptr_ff;
    logic [4:0] nxt_ptr;
    logic       ack_en_ff;
    logic       nxt_ack_en;
    logic       sel_ff;
    logic       nxt_sel;
    logic       oe_n_ff;
    logic       nxt_oe_n;
    logic       bus_we;
    logic [7:0] mem_rdata;

    // Byte as it stands once the current bit is shifted in
    wire [7:0] sh_in_w            = {sh_ff[6:0], lk_bit_ff};
    wire       addr_match_w       = (sh_in_w[7:1] == rtw_pkg::SLAVE_ADDR7);
    wire [7:0] word_address_value = sh_ff;
    // Out-of-map word addresses land on the first location
    wire       word_in_map_w      = (word_address_value < 8'(NUM_REGS));
    wire [4:0] ptr_load_w         = word_in_map_w ? word_address_value[4:0]
                                                  : rtw_pkg::FIRST_ADDR;
    wire       is_rx_state_w      = (state_ff == rtw_pkg::ST_ADDR)
                                  | (state_ff == rtw_pkg::ST_WORD)
                                  | (state_ff == rtw_pkg::ST_WDATA);

    // Next-state logic; stop and start take priority over bit events
    always_comb begin
        nxt_state  = state_ff;
        nxt_bitn   = bitn_ff;
        nxt_sh     = sh_ff;
        nxt_tx     = tx_ff;
        nxt_ptr    = ptr_ff;
        nxt_ack_en = ack_en_ff;
        nxt_sel    = sel_ff;
        nxt_oe_n   = oe_n_ff;
        bus_we     = 1'b0;
        if (stop_det) begin
            nxt_state  = rtw_pkg::ST_IDLE;
            nxt_bitn   = rtw_pkg::BIT_FIRST;
            nxt_ack_en = 1'b0;
            nxt_sel    = 1'b0;
            nxt_oe_n   = 1'b1;
        end else if (start_det) begin
            nxt_state  = rtw_pkg::ST_ADDR;
            nxt_bitn   = rtw_pkg::BIT_FIRST;
            nxt_ack_en = 1'b0;
            nxt_oe_n   = 1'b1;
        end else if (rise_ev && (state_ff != rtw_pkg::ST_IDLE)) begin
            if (bitn_ff != rtw_pkg::BIT_ACK) begin
                nxt_sh   = sh_in_w;
                nxt_bitn = 4'(bitn_ff + 4'h1);
                if (bitn_ff == rtw_pkg::BIT_LAST_DATA) begin
                    nxt_ack_en = is_rx_state_w
                               & ((state_ff != rtw_pkg::ST_ADDR) | addr_match_w);
                end
            end else begin
                nxt_bitn   = rtw_pkg::BIT_FIRST;
                nxt_ack_en = 1'b0;
                case (state_ff)
                    rtw_pkg::ST_ADDR: begin
                        if (ack_en_ff) begin
                            nxt_sel = 1'b1;
                            // direction zero writes; one reads at pointer
                            nxt_state = sh_ff[0] ? rtw_pkg::ST_RDATA : rtw_pkg::ST_WORD;
                        end else begin
                            nxt_state = rtw_pkg::ST_IDLE;
                        end
                    end
                    rtw_pkg::ST_WORD: begin
                        nxt_ptr   = ptr_load_w;
                        nxt_state = rtw_pkg::ST_WDATA;
                    end
                    rtw_pkg::ST_WDATA: begin
                        // store at pointer
                        // The byte completed at the eighth rise is the one stored
                        bus_we  = 1'b1;
                        nxt_ptr = ptr_inc(ptr_ff);
                    end
                    rtw_pkg::ST_RDATA: begin
                        // advance on ack clock
                        // A refused acknowledge still clocks the pointer on
                        nxt_ptr = ptr_inc(ptr_ff);
                        if (lk_bit_ff) begin
                            nxt_state = rtw_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        nxt_state = rtw_pkg::ST_IDLE;
                    end
                endcase
            end
        end else if (fall_ev) begin
            if (ack_en_ff && (bitn_ff == rtw_pkg::BIT_ACK)) begin
                nxt_oe_n = 1'b0;
            end else if ((state_ff == rtw_pkg::ST_RDATA) && (bitn_ff < rtw_pkg::BIT_ACK)) begin
                if (bitn_ff == rtw_pkg::BIT_FIRST) begin
                    // next byte latched; first one is the pointed byte
                    nxt_tx   = mem_rdata;
                    nxt_oe_n = mem_rdata[7];
                end else begin
                    nxt_oe_n = tx_ff[~bitn_ff[2:0]];
                end
            end else begin
                nxt_oe_n = 1'b1;
            end
        end
    end

    // Protocol registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= rtw_pkg::ST_IDLE;
            bitn_ff   <= rtw_pkg::BIT_FIRST;
            sh_ff     <= rtw_pkg::BYTE_RESET;
            tx_ff     <= rtw_pkg::BYTE_RESET;
            ptr_ff    <= rtw_pkg::PTR_RESET;
            ack_en_ff <= 1'b0;
            sel_ff    <= 1'b0;
            oe_n_ff   <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            bitn_ff   <= nxt_bitn;
            sh_ff     <= nxt_sh;
            tx_ff     <= nxt_tx;
            ptr_ff    <= nxt_ptr;
            ack_en_ff <= nxt_ack_en;
            sel_ff    <= nxt_sel;
            oe_n_ff   <= nxt_oe_n;
        end
    end

    // Open-drain drive: the pad value is always low, only the enable moves
    logic sda_o_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_o_ff <= rtw_pkg::SDA_DRIVE_VAL;
        end else begin
            sda_o_ff <= rtw_pkg::SDA_DRIVE_VAL;
        end
    end

    // ------------------------------------------------------------------
    // Clock copy hold and core-side write gating. Holding only while
    // selected and on a clock location keeps a multi-byte time read
    // coherent without starving the core during long non-clock access.
    // ------------------------------------------------------------------
    logic hold_ff;
    logic wr_strobe_ff;
    logic [4:0] wr_addr_ff;

    // hold while selected and on clock location
    // The flag persists after a refused acknowledge until the stop arrives
    wire nxt_hold  = nxt_sel & is_clock_addr(nxt_ptr);
    // block core update of held bytes
    wire core_we_g = core_wr_en & ~(hold_ff & is_clock_addr(core_addr));

    // Hold flag and bus write report
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff      <= 1'b0;
            wr_strobe_ff <= 1'b0;
            wr_addr_ff   <= rtw_pkg::PTR_RESET;
        end else begin
            hold_ff      <= nxt_hold;
            wr_strobe_ff <= bus_we;
            if (bus_we) begin
                wr_addr_ff <= ptr_ff;
            end
        end
    end

    // twenty byte locations
    // Bus port wins a same-address collision with the core port
    rtw_regfile #(
        .DEPTH (NUM_REGS),
        .AW    (rtw_pkg::PTR_W),
        .DW    (rtw_pkg::DATA_W)
    ) u_regs (
        .clk     (sys_clk),
        .rst_n   (rst_n),
        .a_we    (bus_we),
        .a_addr  (ptr_ff),
        .a_wdata (sh_ff),
        .a_rdata (mem_rdata),
        .b_we    (core_we_g),
        .b_addr  (core_addr),
        .b_wdata (core_wdata),
        .b_rdata (core_rdata)
    );

    // Every output comes straight from its flop
    assign sda_o           = sda_o_ff;
    assign sda_oe_n        = oe_n_ff;
    assign clk_update_hold = hold_ff;
    assign bus_wr_strobe   = wr_strobe_ff;
    assign bus_wr_addr     = wr_addr_ff;

endmodule // rtw_slave_port
`default_nettype wire

// ---- verilog/rtw_pkg.sv ----
`default_nettype none
package rtw_pkg;

    // Bus identity: seven-bit slave address; with a zero direction bit it forms 8'hD0
    localparam logic [6:0] SLAVE_ADDR7     = 7'h68;
    localparam logic [7:0] ADDR_BYTE_WRITE = 8'hD0;

    // Register space
    localparam int unsigned NUM_REGS       = 20;
    localparam int unsigned PTR_W          = 5;
    localparam int unsigned DATA_W         = 8;
    localparam logic [4:0]  FIRST_ADDR     = 5'h00;
    localparam logic [4:0]  LAST_CLOCK     = 5'h07;
    localparam logic [4:0]  LAST_ADDR      = 5'h13;
    localparam logic [4:0]  PTR_RESET      = 5'h00;

    // Bit positions within a nine-clock byte slot
    localparam logic [3:0]  BIT_FIRST      = 4'h0;
    localparam logic [3:0]  BIT_LAST_DATA  = 4'h7;
    localparam logic [3:0]  BIT_ACK        = 4'h8;

    // Reset levels
    localparam logic        PIN_IDLE       = 1'b1;
    localparam logic        SDA_DRIVE_VAL  = 1'b0;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;

    // Protocol states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_ADDR  = 5'h02,
        ST_WORD  = 5'h04,
        ST_WDATA = 5'h08,
        ST_RDATA = 5'h10
    } rtw_state_t;

endpackage
`default_nettype wire

// ---- verilog/rtw_regfile.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtw_regfile #(
    parameter int unsigned DEPTH = 20,
    parameter int unsigned AW    = 5,
    parameter int unsigned DW    = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          a_we,
    input  wire logic [AW-1:0] a_addr,
    input  wire logic [DW-1:0] a_wdata,
    output var  logic [DW-1:0] a_rdata,
    input  wire logic          b_we,
    input  wire logic [AW-1:0] b_addr,
    input  wire logic [DW-1:0] b_wdata,
    output var  logic [DW-1:0] b_rdata
);

    logic [DW-1:0] mem [DEPTH];

    // Port A (serial bus) wins a same-cycle collision on one address
    wire b_blocked = a_we && (a_addr == b_addr);

    // Storage writes; the array itself carries no reset, it is data
    always_ff @(posedge clk) begin
        if (b_we && !b_blocked) begin
            mem[b_addr] <= b_wdata;
        end
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
    end

    // Registered read ports
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_rdata <= '0;
            b_rdata <= '0;
        end else begin
            a_rdata <= mem[a_addr];
            b_rdata <= mem[b_addr];
        end
    end

endmodule // rtw_regfile
`default_nettype wire

// ---- dv/rtw_master_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Bus master on the far side; the clock line idles high between frames
module rtw_master_model (
    output var  logic scl_clk,
    output var  logic sda_mst,
    input  wire logic sda_wire
);
    logic tick;

    // 15 ns base tick; bus low 1320 ns and high 615 ns per bit
    initial begin
        tick = 1'b0;
        scl_clk = 1'b1;
        sda_mst = 1'b1;
        forever #7.5 tick = ~tick;
    end

    task automatic wait_t(input int n);
        repeat (n) @(posedge tick);
    endtask

    task automatic bit_io(input logic b, output logic r);
        wait_t(44);
        sda_mst = b;
        wait_t(44);
        scl_clk = 1'b1;
        wait_t(41);
        r = sda_wire;
        scl_clk = 1'b0;
    endtask

    task automatic start_c();
        wait_t(44);
        sda_mst = 1'b1;
        wait_t(44);
        scl_clk = 1'b1;
        wait_t(41);
        sda_mst = 1'b0;
        wait_t(41);
        scl_clk = 1'b0;
    endtask

    task automatic stop_c();
        wait_t(44);
        sda_mst = 1'b0;
        wait_t(44);
        scl_clk = 1'b1;
        wait_t(41);
        sda_mst = 1'b1;
        wait_t(88);
    endtask

    // ninth pulse released for the slave acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // master acknowledges all but the last byte read
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(~ack, r);
    endtask
endmodule // rtw_master_model
`default_nettype wire

// ---- dv/rtw_slave_port_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtw_slave_port_sva #(
    parameter int unsigned NUM_REGS = 20
) (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       scl_clk,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_n,
    input wire logic       core_wr_en,
    input wire logic [4:0] core_addr,
    input wire logic [7:0] core_wdata,
    input wire logic [7:0] core_rdata,
    input wire logic       clk_update_hold,
    input wire logic       bus_wr_strobe,
    input wire logic [4:0] bus_wr_addr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Pad only ever pulls low, the pull-up makes the high level
    chk_open_drain: assert property (sda_o == 1'b0)
        else $error("data pad drives high");
    chk_strobe_pulse: assert property (bus_wr_strobe |=> !bus_wr_strobe)
        else $error("store strobe longer than one cycle");
    chk_addr_range: assert property (bus_wr_strobe |-> bus_wr_addr < NUM_REGS)
        else $error("store address out of range");
    chk_addr_moves: assert property ($changed(bus_wr_addr) |-> bus_wr_strobe)
        else $error("store address moved without a store");
    // Sampled clock is asynchronous, so demand a settled high before judging
    chk_sda_stable: assert property (scl_clk && $past(scl_clk, 8) |-> $stable(sda_oe_n))
        else $error("data changed during clock high");
    chk_drive_low: assert property ($changed(sda_oe_n) |-> !scl_clk && !$past(scl_clk, 2))
        else $error("data changed outside clock low");
    chk_stop_release: assert property (scl_clk && $rose(sda_i) |-> ##[1:6] !clk_update_hold)
        else $error("hold not dropped after stop");
    chk_store_slot: assert property (bus_wr_strobe |-> scl_clk && !sda_oe_n)
        else $error("store outside an acknowledged ninth pulse");
    chk_ack_span: assert property ($fell(sda_oe_n) && scl_clk |-> 1'b0)
        else $error("pull-down started with clock high");
endmodule // rtw_slave_port_sva
bind rtw_slave_port rtw_slave_port_sva #(.NUM_REGS(NUM_REGS)) u_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .core_wr_en(core_wr_en), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata), .clk_update_hold(clk_update_hold),
    .bus_wr_strobe(bus_wr_strobe), .bus_wr_addr(bus_wr_addr));
`default_nettype wire

// ---- dv/rtw_slave_port_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtw_slave_port_bench;
    logic       sys_clk;
    logic       rst_n;
    logic       core_wr_en;
    logic [4:0] core_addr;
    logic [7:0] core_wdata;
    wire        scl_clk;
    wire        sda_mst;
    wire        sda_wire;
    wire        sda_o;
    wire        sda_oe_n;
    wire  [7:0] core_rdata;
    wire        hold;
    wire        strobe;
    wire  [4:0] wr_addr;
    int         n_fail;
    int         n_compared;
    int         cycles;

    // Open-drain wire with pull-up
    assign sda_wire = sda_mst & (sda_oe_n | sda_o);

    rtw_slave_port u_rtw_slave_port (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .core_wr_en(core_wr_en),
        .core_addr(core_addr), .core_wdata(core_wdata), .core_rdata(core_rdata),
        .clk_update_hold(hold), .bus_wr_strobe(strobe), .bus_wr_addr(wr_addr));
    rtw_master_model u_master (.scl_clk(scl_clk), .sda_mst(sda_mst), .sda_wire(sda_wire));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic core_wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        core_wr_en <= 1'b1;
        core_addr <= a;
        core_wdata <= d;
        @(posedge sys_clk);
        core_wr_en <= 1'b0;
    endtask

    task automatic core_chk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        core_addr <= a;
        repeat (3) @(posedge sys_clk);
        check(core_rdata, exp, "core read");
    endtask

    // Bus byte with acknowledge expected as given
    task automatic tx(input logic [7:0] b, input logic exp_ack);
        logic ack;
        u_master.send_byte(b, ack);
        check(ack, exp_ack, "acknowledge");
    endtask

    task automatic rx(input logic ack, input logic [7:0] exp);
        logic [7:0] b;
        u_master.recv_byte(ack, b);
        check(b, exp, "read byte");
    endtask

    // Pointer write then three stores crossing out of the clock bytes
    task automatic t_write_clock();
        u_master.start_c();
        tx(8'hD0, 1'b1);
        tx(8'h06, 1'b1);
        tx(8'hA5, 1'b1);
        check(wr_addr, 5'h06, "store address");
        check(hold, 1'b1, "hold on clock byte");
        tx(8'h5A, 1'b1);
        check(wr_addr, 5'h07, "store address");
        check(hold, 1'b0, "hold off past clock bytes");
        tx(8'hC3, 1'b1);
        check(wr_addr, 5'h08, "store address");
        u_master.stop_c();
        core_chk(5'h06, 8'hA5);
        core_chk(5'h08, 8'hC3);
    endtask

    // Store at the last byte, then a pointer-less read from the wrapped pointer
    task automatic t_wrap_alt();
        u_master.start_c();
        tx(8'hD0, 1'b1);
        tx(8'h13, 1'b1);
        tx(8'h3C, 1'b1);
        u_master.stop_c();
        core_chk(5'h13, 8'h3C);
        u_master.start_c();
        tx(8'hD1, 1'b1);
        rx(1'b1, 8'h11);
        check(hold, 1'b1, "hold while reading clock");
        core_wr(5'h00, 8'hEE);
        rx(1'b0, 8'h22);
        u_master.stop_c();
        check(hold, 1'b0, "hold after stop");
        core_chk(5'h00, 8'h11);
        core_wr(5'h00, 8'h33);
        core_chk(5'h00, 8'h33);
    endtask

    // Addressed read with repeated start across the clock boundary
    task automatic t_addr_read();
        u_master.start_c();
        tx(8'hD0, 1'b1);
        tx(8'h06, 1'b1);
        u_master.start_c();
        tx(8'hD1, 1'b1);
        rx(1'b1, 8'hA5);
        rx(1'b1, 8'h5A);
        rx(1'b0, 8'hC3);
        u_master.stop_c();
    endtask

    // Foreign address is never acknowledged
    task automatic t_wrong_addr();
        u_master.start_c();
        tx(8'hD2, 1'b0);
        u_master.stop_c();
        check(sda_wire, 1'b1, "bus left idle");
    endtask

    // Cut a hang short at 400 us, only about 55 us past the expected run length of about 345 us
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        n_fail = 0;
        n_compared = 0;
        cycles = 0;
        rst_n = 1'b0;
        core_wr_en = 1'b0;
        core_addr = 5'h00;
        core_wdata = 8'h00;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        core_wr(5'h00, 8'h11);
        core_wr(5'h01, 8'h22);
        t_write_clock();
        t_wrap_alt();
        t_addr_read();
        t_wrong_addr();
        conclude();
    end
endmodule // rtw_slave_port_bench
`default_nettype wire
